/* logic/crro_consts.svh */
// Constants for the return and rotate instruction block.
// Assumes a 14-bit instruction word and an 8-bit data path.
`ifndef CRRO_CONSTS_SVH
`define CRRO_CONSTS_SVH
`define CRRO_OPC_LIT_HI     4'hd
`define CRRO_OPC_ROT_HI     6'h0c
`define CRRO_OPC_CFG        14'h0062
`define CRRO_OPC_POP        14'h0008
`define CRRO_ROT_DEST_BIT   7
`define CRRO_GRP_MSB        13
`define CRRO_LIT_GRP_LSB    10
`define CRRO_ROT_GRP_LSB    8
`define CRRO_LIT_MSB        7
`define CRRO_LIT_LSB        0
`define CRRO_DATA_LSB       0
`define CRRO_FREG_RESET     8'h00
`define CRRO_W_RESET        8'h00
`define CRRO_CFG_RESET      8'hff
`define CRRO_PC_RESET       13'h0000
`endif

/* logic/crro_pkg.sv */
// Types shared by the return and rotate instruction block.
// Assumes the consts header is included where numbers are needed.
package crro_pkg;
   typedef enum logic [1:0] {crro_exec, crro_flush} crro_state_t;
endpackage

/* logic/crro_core.sv */
// Executes config-load, literal return, plain return and rotate-right-through-carry.
// Assumes a fetch unit presents one instruction per enabled cycle and a stack that pops on request.
`include "crro_consts.svh"

module crro_core
#(
   parameter int PC_W   = 13,
   parameter int FADR_W = 7
)
(
   input  wire logic              clock,
   input  wire logic              resetn,
   input  wire logic              cycle_en,
   input  wire logic [13:0]       instr,
   input  wire logic [7:0]        file_rdata,
   input  wire logic [PC_W-1:0]   stack_top,
   input  wire logic              cfg_wr,
   input  wire logic [7:0]        cfg_wdata,
   output logic      [FADR_W-1:0] file_addr,
   output logic                   file_we,
   output logic      [7:0]        file_wdata,
   output logic                   stack_pop,
   output logic                   pc_load,
   output logic      [PC_W-1:0]   pc,
   output logic      [7:0]        w,
   output logic                   carry,
   output logic      [7:0]        timer_cfg,
   output logic                   busy
);
   localparam int DATA_W = 8;

   logic                  rst_s1;
   logic                  rst_n;
   crro_pkg::crro_state_t state;
   crro_pkg::crro_state_t next_state;
   logic [DATA_W-1:0]     next_w;
   logic                  next_carry;
   logic [PC_W-1:0]       next_pc;
   logic [DATA_W-1:0]     next_timer_cfg;

   // Field matchers; the don't-care bits of an encoding take no part in the compare
   function automatic logic match_lit(input logic [13:0] word);
      return word[`CRRO_GRP_MSB:`CRRO_LIT_GRP_LSB] == `CRRO_OPC_LIT_HI;
   endfunction

   function automatic logic match_rot(input logic [13:0] word);
      return word[`CRRO_GRP_MSB:`CRRO_ROT_GRP_LSB] == `CRRO_OPC_ROT_HI;
   endfunction

   function automatic logic match_word(input logic [13:0] word, input logic [13:0] code);
      return word == code;
   endfunction

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // Decode; instructions are ignored in the flush cycle of a two-cycle return
   wire              executing   = cycle_en && (state == crro_pkg::crro_exec);
   wire              is_lit      = executing && match_lit(instr);
   wire              is_pop      = executing && match_word(instr, `CRRO_OPC_POP);
   wire              is_cfg      = executing && match_word(instr, `CRRO_OPC_CFG);
   wire              is_rot      = executing && match_rot(instr);
   wire              rot_to_f    = instr[`CRRO_ROT_DEST_BIT];
   wire              rot_to_w    = is_rot && !rot_to_f;
   wire              flow_change = is_lit || is_pop;
   wire [DATA_W-1:0] rot_result;

   // Each bit takes its upper neighbour; the old carry fills the top
   genvar bit_i;
   generate
      for (bit_i = 0; bit_i < DATA_W - 1; bit_i++)
      begin : g_rot
         assign rot_result[bit_i] = file_rdata[bit_i + 1];
      end
   endgenerate
   assign rot_result[DATA_W-1] = carry;

   assign file_addr  = instr[FADR_W-1:0];
   assign file_we    = is_rot && rot_to_f;
   assign file_wdata = rot_result;
   assign stack_pop  = flow_change;
   assign pc_load    = flow_change;
   assign busy       = (state == crro_pkg::crro_flush);

   // Second cycle discards the prefetched word after the flow change
   always_comb
   begin
      next_state = state;
      case (state)
         crro_pkg::crro_exec:
         begin
            if (flow_change)
            begin
               next_state = crro_pkg::crro_flush;
            end
         end
         crro_pkg::crro_flush:
         begin
            if (cycle_en)
            begin
               next_state = crro_pkg::crro_exec;
            end
         end
         default:
         begin
            next_state = crro_pkg::crro_exec;
         end
      endcase
   end

   always_comb
   begin
      next_w = w;
      if (is_lit)
      begin
         next_w = instr[`CRRO_LIT_MSB:`CRRO_LIT_LSB];
      end
      else if (rot_to_w)
      begin
         next_w = rot_result;
      end
   end

   // Only a rotate touches carry; returns and the config load leave status alone
   always_comb
   begin
      next_carry = carry;
      if (is_rot)
      begin
         next_carry = file_rdata[`CRRO_DATA_LSB];
      end
   end

   always_comb
   begin
      next_pc = pc;
      if (pc_load)
      begin
         next_pc = stack_top;
      end
   end

   // Instruction load wins over a same-cycle file-bus write
   always_comb
   begin
      next_timer_cfg = timer_cfg;
      if (is_cfg)
      begin
         next_timer_cfg = w;
      end
      else if (cfg_wr)
      begin
         next_timer_cfg = cfg_wdata;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= crro_pkg::crro_exec;
      end
      else
      begin
         state <= next_state;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pc <= `CRRO_PC_RESET;
      end
      else
      begin
         pc <= next_pc;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         w <= `CRRO_W_RESET;
      end
      else
      begin
         w <= next_w;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         carry <= 1'b0;
      end
      else
      begin
         carry <= next_carry;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         timer_cfg <= `CRRO_CFG_RESET;
      end
      else
      begin
         timer_cfg <= next_timer_cfg;
      end
   end
endmodule

/* bench/crro_core_sva.sv */
// Port checker for crro_core.
// Assumes default widths: 14-bit word, 13-bit pc.
module crro_core_sva (
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic        cycle_en,
   input wire logic        busy,
   input wire logic        stack_pop,
   input wire logic        pc_load,
   input wire logic        file_we,
   input wire logic        carry,
   input wire logic        cfg_wr,
   input wire logic [13:0] instr,
   input wire logic [7:0]  file_rdata,
   input wire logic [7:0]  file_wdata,
   input wire logic [7:0]  w,
   input wire logic [7:0]  timer_cfg,
   input wire logic [7:0]  cfg_wdata,
   input wire logic [12:0] stack_top,
   input wire logic [12:0] pc
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   wire tk  = cycle_en && !busy;
   wire lit = tk && instr[13:10] == 4'hd;
   wire rot = tk && instr[13:8] == 6'h0c;
   wire cfg = tk && instr == 14'h0062;
   lit_w_a: assert property (lit |=> w == $past(instr[7:0])) else $error("lit w");
   lit_pc_a: assert property (lit |-> pc_load ##1 pc == $past(stack_top)) else $error("lit pc");
   ret_flush_a: assert property (stack_pop |=> busy && !stack_pop) else $error("flush");
   flush_hold_a: assert property (busy |=> $stable(w) && $stable(carry) && $stable(pc))
      else $error("flush hold");
   flush_end_a: assert property (busy && cycle_en |=> !busy) else $error("flush end");
   rot_carry_a: assert property (rot |=> carry == $past(file_rdata[0])) else $error("rot c");
   rot_dest_a: assert property (rot |-> file_we == instr[7] && file_wdata == {carry, file_rdata[7:1]})
      else $error("rot d");
   cfg_load_a: assert property (cfg |=> timer_cfg == $past(w)) else $error("cfg");
   cfg_file_a: assert property (cfg_wr && !cfg |=> timer_cfg == $past(cfg_wdata)) else $error("cfg file");
   pop_keep_a: assert property (tk && instr == 14'h0008 |=> pc == $past(stack_top) && $stable(w) && $stable(carry))
      else $error("pop");
endmodule
bind crro_core crro_core_sva sva_u (.clock, .resetn, .cycle_en, .busy, .stack_pop, .pc_load, .file_we, .carry,
   .cfg_wr, .instr, .file_rdata, .file_wdata, .w, .timer_cfg, .cfg_wdata, .stack_top, .pc);

/* bench/cpu_return_rotate_ops_test.sv */
// Directed bench for crro_core.
// Assumes the bench stands in for fetch, file registers and stack.
module cpu_return_rotate_ops_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, resetn = 0, cycle_en = 0, cfg_wr = 0;
   logic [13:0] instr = 0;
   logic [7:0] file_rdata = 0, cfg_wdata = 0;
   logic [12:0] stack_top = 0;
   wire [6:0] file_addr;
   wire file_we, stack_pop, pc_load, carry, busy;
   wire [7:0] file_wdata, w, timer_cfg;
   wire [12:0] pc;
   int fails = 0, tests_run = 0, cyc = 0;
   always #10 clock = ~clock;
   crro_core dut_u (.clock, .resetn, .cycle_en, .instr, .file_rdata, .stack_top, .cfg_wr, .cfg_wdata,
      .file_addr, .file_we, .file_wdata, .stack_pop, .pc_load, .pc, .w, .carry, .timer_cfg, .busy);
   task chk(input string n, input logic [12:0] e, input logic [12:0] g);
      tests_run++;
      if (g !== e)
      begin
         fails++;
         $display("ERROR %s exp %h got %h", n, e, g);
      end
   endtask
   task close_out;
      if (fails == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task go(input logic [13:0] i);
      @(posedge clock);
      #1 instr = i;
      cycle_en = 1;
      // Let the combinational outputs settle before they are judged
      #4;
   endtask
   task fin;
      @(posedge clock);
      #1 cycle_en = 0;
   endtask
   task t_lit;
      stack_top = 13'h0abc;
      go(14'h34aa);
      chk("pop", 1, stack_pop & pc_load);
      go(14'h3455);
      chk("w", 8'haa, w);
      chk("pc", 13'h0abc, pc);
      chk("busy", 1, busy);
      chk("pop2", 0, stack_pop);
      fin;
      chk("w2", 8'haa, w);
      chk("busy2", 0, busy);
   endtask
   task t_rot;
      file_rdata = 8'he6;
      go(14'h0c23);
      chk("wd", 8'h73, file_wdata);
      chk("fadr", 7'h23, file_addr);
      chk("we", 0, file_we);
      fin;
      chk("w", 8'h73, w);
      file_rdata = 8'h01;
      go(14'h0ca3);
      chk("we1", 1, file_we);
      fin;
      chk("c", 1, carry);
      chk("w1", 8'h73, w);
      file_rdata = 8'h03;
      go(14'h0c23);
      chk("wd1", 8'h81, file_wdata);
      fin;
      chk("w3", 8'h81, w);
      chk("c1", 1, carry);
   endtask
   task t_cfg;
      cfg_wr = 1;
      cfg_wdata = 8'h5a;
      @(posedge clock);
      #1 cfg_wr = 0;
      chk("fa", 8'h5a, timer_cfg);
      go(14'h0062);
      fin;
      chk("cfg", 8'h81, timer_cfg);
   endtask
   task t_ret;
      stack_top = 13'h1234;
      go(14'h0008);
      chk("pop", 1, stack_pop);
      go(14'h34ff);
      chk("pc", 13'h1234, pc);
      fin;
      chk("w", 8'h81, w);
      chk("c", 1, carry);
   endtask
   task t_rst;
      @(posedge clock);
      #1 resetn = 0;
      #1;
      chk("rst_w2", 0, w);
      chk("rst_pc", 0, pc);
      chk("rst_c", 0, carry);
      chk("rst_cfg", 8'hff, timer_cfg);
      @(posedge clock);
      #1 resetn = 1;
      repeat (2) @(posedge clock);
      stack_top = 13'h0456;
      go(14'h3411);
      chk("pop3", 1, stack_pop);
      go(14'h0000);
      chk("pc3", 13'h0456, pc);
      fin;
      chk("w4", 8'h11, w);
      chk("busy3", 0, busy);
   endtask
   // A hang counts as a mismatch so it can never reach the pass verdict
   always @(posedge clock)
   begin
      cyc++;
      if (cyc > 2000)
      begin
         fails++;
         close_out;
      end
   end
   initial
   begin
      repeat (20) @(posedge clock);
      #1 resetn = 1;
      repeat (3) @(posedge clock);
      #1;
      chk("rst", 8'hff, timer_cfg);
      chk("rst_w", 0, w);
      chk("rst_busy", 0, busy);
      t_lit;
      t_rot;
      t_cfg;
      t_ret;
      t_rst;
      close_out;
   end
endmodule
